// File: auxldo_ctrl.sv
// Purpose: mode, strap and software control of the auxiliary regulator
// Assumes: inputs synchronous to clk_sys_in; software accesses are one-cycle strobes
// Notes: lock is cleared only by the power-on reset
`timescale 1ns/10ps

// How it works
// - four voltages selectable, 3.3 V after reset
// - strap open: off init/failsafe, normal follows software
// - strap grounded: fixed 3.3 V, off sleep/failsafe
// - first enable locks voltage until power loss
// - enable bit still toggles after lock
// - overcurrent sets flag, no other action
// - flag sticks until cleared after condition ends
// - strap open: undervoltage to regulator flag
// - strap grounded: undervoltage to I/O flag
// - overcurrent flag reported in status
module auxldo_ctrl (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // chip context
  input wire auxldo_pkg::auxldo_mode_t mode_in,
  input wire logic supply_profile_strap_gnd_in,
  // analogue sense
  input wire logic shunt_sense_pin_oc_in,
  input wire logic aux_supply_out_uv_in,
  // software side
  input wire auxldo_pkg::auxldo_sw_t sw_in,
  // outputs
  output auxldo_pkg::auxldo_drive_t drive_out,
  output auxldo_pkg::auxldo_stat_t stat_out
);
  import auxldo_pkg::*;

  // =====================================================
  // reset release
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // =====================================================
  // software configuration
  auxldo_vsel_t vsel_q;
  logic en_q;
  logic lock_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      vsel_q <= AUXLDO_VSEL_RST;
    end else if (sw_in.vsel_wr && !lock_q) begin
      vsel_q <= sw_in.vsel;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_q <= AUXLDO_EN_RST;
    end else if (sw_in.en_wr) begin
      en_q <= sw_in.aux_regulator_enable_bit;
    end
  end

  // lock sticks: a later disable does not reopen the voltage setting
  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_q <= 1'b0;
    end else if (sw_in.en_wr && sw_in.aux_regulator_enable_bit) begin
      lock_q <= 1'b1;
    end
  end

  // =====================================================
  // mode decode
  logic on_d;
  auxldo_vsel_t vsel_d;
  logic hold_mode;

  always_comb begin
    hold_mode = 1'b0;
    on_d = 1'b0;
    vsel_d = vsel_q;
    if (supply_profile_strap_gnd_in) begin
      vsel_d = AUXLDO_VSEL_STRAP;
      unique case (mode_in)
        AUXLDO_M_SLEEP, AUXLDO_M_FAILSAFE: on_d = 1'b0;
        AUXLDO_M_INIT, AUXLDO_M_NORMAL, AUXLDO_M_STOP,
        AUXLDO_M_RESTART: on_d = 1'b1;
        default: on_d = 1'b0;
      endcase
    end else begin
      unique case (mode_in)
        AUXLDO_M_INIT, AUXLDO_M_FAILSAFE: on_d = 1'b0;
        AUXLDO_M_NORMAL: on_d = en_q;
        AUXLDO_M_STOP, AUXLDO_M_SLEEP, AUXLDO_M_RESTART: hold_mode = 1'b1;
        default: on_d = 1'b0;
      endcase
    end
  end

  // with the strap open, in stop, sleep and restart the drive keeps its previous value
  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drive_out <= '{on: 1'b0, vsel: AUXLDO_VSEL_RST};
    end else if (!hold_mode) begin
      drive_out <= '{on: on_d, vsel: vsel_d};
    end
  end

  // =====================================================
  // overcurrent and undervoltage status
  logic oc_q;

  // set wins over clear, so a clear during the condition is lost
  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      oc_q <= 1'b0;
    end else if (shunt_sense_pin_oc_in) begin
      oc_q <= 1'b1;
    end else if (sw_in.oc_clr) begin
      oc_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_out <= '0;
    end else begin
      stat_out.aux_overcurrent_flag <= oc_q || shunt_sense_pin_oc_in;
      stat_out.regulator_undervoltage_flag <= aux_supply_out_uv_in
                                              && !supply_profile_strap_gnd_in;
      stat_out.io_supply_undervoltage_flag <= aux_supply_out_uv_in
                                              && supply_profile_strap_gnd_in;
      stat_out.cfg_locked <= lock_q;
      stat_out.aux_regulator_enable_bit <= en_q;
      stat_out.vsel <= vsel_q;
    end
  end

  // =====================================================
  // checks
  lock_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    lock_q |=> (lock_q && $stable(vsel_q)))
    else $error("voltage setting changed after lock");

  en_after_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (lock_q && sw_in.en_wr) |=> (en_q == $past(sw_in.aux_regulator_enable_bit)))
    else $error("enable write ignored after lock");

  strap_fixed_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (supply_profile_strap_gnd_in && mode_in == AUXLDO_M_NORMAL)
    |=> (drive_out.on && drive_out.vsel == AUXLDO_V3P3))
    else $error("strap grounded normal mode not fixed 3.3 V on");

  open_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!supply_profile_strap_gnd_in && (mode_in == AUXLDO_M_INIT
      || mode_in == AUXLDO_M_FAILSAFE)) |=> !drive_out.on)
    else $error("regulator on in init or failsafe");

  open_normal_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!supply_profile_strap_gnd_in && mode_in == AUXLDO_M_NORMAL)
    |=> (drive_out.on == $past(en_q) && drive_out.vsel == $past(vsel_q)))
    else $error("normal mode does not follow software");

  oc_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    shunt_sense_pin_oc_in |=> oc_q ##1 stat_out.aux_overcurrent_flag)
    else $error("overcurrent flag not held");

  oc_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (oc_q && sw_in.oc_clr && !shunt_sense_pin_oc_in) |=> !oc_q)
    else $error("overcurrent clear failed");

  oc_no_action_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (shunt_sense_pin_oc_in && !hold_mode) |=> (drive_out.on == $past(on_d)))
    else $error("overcurrent changed the regulator state");

  uv_route_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    aux_supply_out_uv_in |=> (stat_out.regulator_undervoltage_flag
      != stat_out.io_supply_undervoltage_flag))
    else $error("undervoltage not routed to exactly one flag");

  reset_vsel_a: assert property (@(posedge clk_sys_in)
    $rose(rst_n_q) |-> vsel_q == AUXLDO_V3P3)
    else $error("voltage not 3.3 V after reset");

  reset_state_a: assert property (@(posedge clk_sys_in)
    $rose(rst_n_q) |-> (!lock_q && !en_q && !oc_q && !drive_out.on
      && drive_out.vsel == AUXLDO_VSEL_RST))
    else $error("state not at reset values after reset");

  // =====================================================
  // checks on configuration and lock
  // helper: the setting as it stood when the lock closed, so the check
  // spans the whole locked period and not only neighbouring edges
  logic lock_seen_q;
  auxldo_vsel_t vsel_at_lock_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_seen_q <= 1'b0;
      vsel_at_lock_q <= AUXLDO_VSEL_RST;
    end else begin
      lock_seen_q <= lock_q;
      if (!lock_seen_q) begin
        vsel_at_lock_q <= vsel_q;
      end
    end
  end

  lock_value_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    lock_seen_q |-> (vsel_q == vsel_at_lock_q))
    else $error("voltage setting drifted while locked");

  vsel_take_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (sw_in.vsel_wr && !lock_q) |=> (vsel_q == $past(sw_in.vsel)))
    else $error("voltage write before lock not taken");

  vsel_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (sw_in.vsel_wr && lock_q) |=> $stable(vsel_q))
    else $error("voltage write after lock changed the setting");

  lock_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (sw_in.en_wr && sw_in.aux_regulator_enable_bit) |=> lock_q)
    else $error("first enable did not close the lock");

  lock_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!lock_q && !(sw_in.en_wr && sw_in.aux_regulator_enable_bit)) |=> !lock_q)
    else $error("lock closed without an enable write");

  en_take_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    sw_in.en_wr |=> (en_q == $past(sw_in.aux_regulator_enable_bit)))
    else $error("enable write not taken");

  en_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    !sw_in.en_wr |=> $stable(en_q))
    else $error("enable bit changed without a write");

  // =====================================================
  // checks on mode decode
  gnd_on_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (supply_profile_strap_gnd_in && (mode_in == AUXLDO_M_INIT || mode_in == AUXLDO_M_STOP
      || mode_in == AUXLDO_M_RESTART)) |=> drive_out.on)
    else $error("strap grounded regulator off in an on mode");

  gnd_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (supply_profile_strap_gnd_in && (mode_in == AUXLDO_M_SLEEP
      || mode_in == AUXLDO_M_FAILSAFE)) |=> !drive_out.on)
    else $error("strap grounded regulator on in sleep or failsafe");

  gnd_vsel_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    supply_profile_strap_gnd_in |=> (drive_out.vsel == AUXLDO_VSEL_STRAP))
    else $error("strap grounded voltage follows software");

  open_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!supply_profile_strap_gnd_in && (mode_in == AUXLDO_M_STOP || mode_in == AUXLDO_M_SLEEP
      || mode_in == AUXLDO_M_RESTART)) |=> $stable(drive_out))
    else $error("drive changed in stop, sleep or restart");

  // =====================================================
  // checks on status
  oc_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (oc_q && !sw_in.oc_clr) |=> oc_q)
    else $error("overcurrent flag dropped without a clear");

  oc_clr_blocked_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (sw_in.oc_clr && shunt_sense_pin_oc_in) |=> oc_q)
    else $error("overcurrent flag cleared during the condition");

  oc_self_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!oc_q && !shunt_sense_pin_oc_in) |=> !oc_q)
    else $error("overcurrent flag set without the condition");

  oc_report_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (oc_q || shunt_sense_pin_oc_in) |=> stat_out.aux_overcurrent_flag)
    else $error("overcurrent not reported in status");

  oc_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (!oc_q && !shunt_sense_pin_oc_in) |=> !stat_out.aux_overcurrent_flag)
    else $error("overcurrent reported without cause");

  uv_open_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (aux_supply_out_uv_in && !supply_profile_strap_gnd_in)
    |=> (stat_out.regulator_undervoltage_flag && !stat_out.io_supply_undervoltage_flag))
    else $error("strap open undervoltage not on regulator flag");

  uv_gnd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    (aux_supply_out_uv_in && supply_profile_strap_gnd_in)
    |=> (stat_out.io_supply_undervoltage_flag && !stat_out.regulator_undervoltage_flag))
    else $error("strap grounded undervoltage not on io flag");

  uv_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    !aux_supply_out_uv_in
    |=> (!stat_out.regulator_undervoltage_flag && !stat_out.io_supply_undervoltage_flag))
    else $error("undervoltage reported without cause");

  stat_mirror_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    1'b1 |=> (stat_out.cfg_locked == $past(lock_q)
      && stat_out.aux_regulator_enable_bit == $past(en_q)))
    else $error("status does not mirror lock and enable");

  // status vsel resets to zero, so the first edge after release is skipped
  stat_vsel_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    $past(rst_n_q) |=> (stat_out.vsel == $past(vsel_q)))
    else $error("status does not report the voltage setting");

  lock_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    lock_q && sw_in.vsel_wr);
  oc_clr_blocked_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    shunt_sense_pin_oc_in && sw_in.oc_clr);
  hold_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    drive_out.on && hold_mode);
  gnd_on_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    supply_profile_strap_gnd_in && drive_out.on);
  oc_clear_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_q)
    oc_q && sw_in.oc_clr && !shunt_sense_pin_oc_in);

endmodule

// File: auxldo_pkg.sv
// Purpose: shared types and constants for the auxiliary regulator mode control
// Assumes: one system clock, no register bus
// Notes: voltage codes follow the order 5.0, 3.3, 1.8, 1.2 V
package auxldo_pkg;

  // =====================================================
  // voltage selection
  typedef enum logic [1:0] {
    AUXLDO_V5P0 = 2'h0,
    AUXLDO_V3P3 = 2'h1,
    AUXLDO_V1P8 = 2'h2,
    AUXLDO_V1P2 = 2'h3
  } auxldo_vsel_t;

  localparam auxldo_vsel_t AUXLDO_VSEL_RST = AUXLDO_V3P3;
  localparam auxldo_vsel_t AUXLDO_VSEL_STRAP = AUXLDO_V3P3;
  localparam logic AUXLDO_EN_RST = 1'b0;

  // =====================================================
  // chip operating modes
  typedef enum logic [2:0] {
    AUXLDO_M_INIT = 3'h0,
    AUXLDO_M_NORMAL = 3'h1,
    AUXLDO_M_STOP = 3'h2,
    AUXLDO_M_SLEEP = 3'h3,
    AUXLDO_M_RESTART = 3'h4,
    AUXLDO_M_FAILSAFE = 3'h5
  } auxldo_mode_t;

  // =====================================================
  // software write strobes and data
  typedef struct packed {
    logic vsel_wr;
    auxldo_vsel_t vsel;
    logic en_wr;
    logic aux_regulator_enable_bit;
    logic oc_clr;
  } auxldo_sw_t;

  // regulator drive towards the analogue part
  typedef struct packed {
    logic on;
    auxldo_vsel_t vsel;
  } auxldo_drive_t;

  // status bits towards the supply status registers
  typedef struct packed {
    logic aux_overcurrent_flag;
    logic regulator_undervoltage_flag;
    logic io_supply_undervoltage_flag;
    logic cfg_locked;
    logic aux_regulator_enable_bit;
    auxldo_vsel_t vsel;
  } auxldo_stat_t;

endpackage

// File: auxldo_sw_model.sv
// Purpose: software side model that issues one-cycle control strobes
// Assumes: strobes launched at the falling edge, held for one full cycle
// Notes: strobes never overlap; one idle cycle separates two of them
`timescale 1ns/10ps
module auxldo_sw_model (
  // clock
  input wire logic clk_sys_in,
  // strobes towards the block
  output auxldo_pkg::auxldo_sw_t sw_out
);
  import auxldo_pkg::*;
  initial sw_out = '0;
  // =====================================================
  // strobe launch
  task automatic send(input auxldo_sw_t s);
    @(negedge clk_sys_in);
    sw_out = s;
    @(negedge clk_sys_in);
    sw_out = '0;
  endtask
  // the bench writes the voltage before the first enable
  task automatic set_vsel(input auxldo_vsel_t v);
    send(auxldo_sw_t'({1'b1, v, 3'h0}));
  endtask
  task automatic set_en(input logic b);
    send(auxldo_sw_t'({3'h0, 1'b1, b, 1'b0}));
  endtask
  task automatic clear_oc();
    send(auxldo_sw_t'(6'h01));
  endtask
endmodule

// File: auxldo_ctrl_tb.sv
// Purpose: self-checking bench for the auxiliary regulator control
// Assumes: inputs change at the falling edge
// Notes: software strobes come from the partner model
`timescale 1ns/10ps
module auxldo_ctrl_tb;
  import auxldo_pkg::*;
  logic clk_sys_in, arst_n_in, strap, oc, uv;
  auxldo_mode_t mode;
  auxldo_sw_t sw;
  auxldo_drive_t drv;
  auxldo_stat_t st;
  int err_total = 0;
  int check_count = 0;
  auxldo_ctrl u_auxldo_ctrl (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .mode_in(mode),
    .supply_profile_strap_gnd_in(strap), .shunt_sense_pin_oc_in(oc),
    .aux_supply_out_uv_in(uv), .sw_in(sw), .drive_out(drv), .stat_out(st));
  auxldo_sw_model u_auxldo_sw_model (.clk_sys_in(clk_sys_in), .sw_out(sw));
  // =====================================================
  // clock and helpers
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // registered outputs need two edges; three gives margin
  task automatic settle();
    repeat (3) @(negedge clk_sys_in);
  endtask
  task automatic set_mode(input auxldo_mode_t m);
    @(negedge clk_sys_in);
    mode = m;
    settle();
  endtask
  task automatic chk_drv(input logic on, input auxldo_vsel_t v);
    chk(8'(drv), 8'({on, v}));
  endtask
  // =====================================================
  // scenarios
  task automatic t_open();
    chk_drv(1'b0, AUXLDO_V3P3);
    set_mode(AUXLDO_M_INIT);
    chk(8'(drv.on), 8'h00);
    set_mode(AUXLDO_M_NORMAL);
    for (int i = 0; i < 4; i++) begin
      u_auxldo_sw_model.set_vsel(auxldo_vsel_t'(i));
      settle();
      chk(8'(st.vsel), 8'(i));
      chk_drv(1'b0, auxldo_vsel_t'(i));
    end
    u_auxldo_sw_model.set_en(1'b1);
    settle();
    chk(8'(st.cfg_locked), 8'h01);
    u_auxldo_sw_model.set_vsel(AUXLDO_V5P0);
    settle();
    chk_drv(1'b1, AUXLDO_V1P2);
    u_auxldo_sw_model.set_en(1'b0);
    settle();
    chk_drv(1'b0, AUXLDO_V1P2);
    chk(8'(st.aux_regulator_enable_bit), 8'h00);
    chk(8'(st.cfg_locked), 8'h01);
    u_auxldo_sw_model.set_en(1'b1);
    settle();
    chk_drv(1'b1, AUXLDO_V1P2);
    for (int m = 2; m < 5; m++) begin
      set_mode(auxldo_mode_t'(m));
      chk_drv(1'b1, AUXLDO_V1P2);
    end
    set_mode(AUXLDO_M_FAILSAFE);
    chk(8'(drv.on), 8'h00);
    uv = 1'b1;
    settle();
    chk(8'({st.regulator_undervoltage_flag, st.io_supply_undervoltage_flag}), 8'h02);
    uv = 1'b0;
  endtask
  task automatic t_gnd();
    logic [5:0] on_tbl;
    on_tbl = 6'h17;
    strap = 1'b1;
    for (int m = 0; m < 6; m++) begin
      set_mode(auxldo_mode_t'(m));
      chk(8'(drv.on), 8'(on_tbl[m]));
      if (on_tbl[m]) begin
        chk_drv(1'b1, AUXLDO_V3P3);
      end
    end
    uv = 1'b1;
    settle();
    chk(8'({st.regulator_undervoltage_flag, st.io_supply_undervoltage_flag}), 8'h01);
    uv = 1'b0;
    strap = 1'b0;
  endtask
  task automatic t_oc();
    set_mode(AUXLDO_M_NORMAL);
    oc = 1'b1;
    settle();
    chk(8'(st.aux_overcurrent_flag), 8'h01);
    chk_drv(1'b1, AUXLDO_V1P2);
    u_auxldo_sw_model.clear_oc();
    settle();
    chk(8'(st.aux_overcurrent_flag), 8'h01);
    @(negedge clk_sys_in);
    oc = 1'b0;
    settle();
    chk(8'(st.aux_overcurrent_flag), 8'h01);
    u_auxldo_sw_model.clear_oc();
    settle();
    chk(8'(st.aux_overcurrent_flag), 8'h00);
  endtask
  // a second reset stands in for a supply loss: the lock must reopen
  task automatic t_rst();
    @(negedge clk_sys_in);
    arst_n_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    chk(8'(st.cfg_locked), 8'h00);
    chk(8'(st.vsel), 8'(AUXLDO_VSEL_RST));
    chk_drv(1'b0, AUXLDO_VSEL_RST);
    u_auxldo_sw_model.set_vsel(AUXLDO_V1P8);
    settle();
    chk_drv(1'b0, AUXLDO_V1P8);
  endtask
  // =====================================================
  // sequence, watchdog and verdict
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    arst_n_in = 1'b0;
    strap = 1'b0;
    oc = 1'b0;
    uv = 1'b0;
    mode = AUXLDO_M_INIT;
    repeat (12) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    t_open();
    t_gnd();
    t_oc();
    t_rst();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_total++;
    stop_test();
  end
endmodule
